// File: verilog/lbc_core.sv
// Contract
// - Register AND with d=0: accumulator AND file register goes to accumulator.
// - Register AND with d=1: result to file register, accumulator kept.
// - Literal AND: accumulator AND low eight instruction bits.
// - Literal AND always writes the accumulator; no destination bit.
`timescale 1ns/10ps
module lbc_core
	import lbc_pkg::*;
(
	input  wire logic                   sys_clk,
	input  wire logic                   nrst,
	input  wire logic [LBC_IW-1:0]      instr,
	input  wire logic                   instr_valid,
	input  wire logic                   acc_wr,
	input  wire logic [LBC_DW-1:0]      acc_wdata,
	input  wire logic [LBC_DW-1:0]      file_rdata,
	output logic      [LBC_FADDR_W-1:0] file_addr,
	output logic      [LBC_DW-1:0]      file_wdata,
	output logic                        file_we,
	output logic      [LBC_DW-1:0]      accum,
	output logic                        zero_flag
);

	lbc_op_t          op;
	logic [LBC_DW-1:0] and_file;
	logic [LBC_DW-1:0] and_lit;
	logic [LBC_DW-1:0] clr_mask;
	logic              dest_file;

	// ********************************************************
	// Decode
	// ********************************************************
	lbc_decode u_dec (
		.instr       (instr),
		.instr_valid (instr_valid),
		.op          (op)
	);

	// Datapath terms; the file word is read in the same cycle
	assign dest_file = instr[LBC_DEST_BIT];
	assign and_file  = accum & file_rdata;
	assign and_lit   = accum & instr[LBC_DW-1:0];

	// Clear mask built per bit; only the selected position drops to zero
	for (genvar gi = 0; gi < LBC_DW; gi++) begin : g_clr_mask
		assign clr_mask[gi] = (instr[LBC_BSEL_LO +: 3] != 3'(gi));
	end

	// ********************************************************
	// Accumulator
	// ********************************************************
	// Without the outside load path the AND ops could never leave the reset value
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			accum <= LBC_ACC_RST;
		end else if (op == LBC_ANDF && !dest_file) begin
			accum <= and_file;
		end else if (op == LBC_ANDL) begin
			accum <= and_lit;
		end else if (acc_wr && op == LBC_NONE) begin
			// Other instructions of the core load it; ours win if both come
			accum <= acc_wdata;
		end
	end

	// ********************************************************
	// Zero flag
	// ********************************************************
	// Bit clear leaves the flag alone, so only AND ops touch it
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			zero_flag <= LBC_ZERO_RST;
		end else if (op == LBC_ANDF) begin
			zero_flag <= (and_file == 8'h00);
		end else if (op == LBC_ANDL) begin
			zero_flag <= (and_lit == 8'h00);
		end
	end

	// ********************************************************
	// File write port
	// ********************************************************
	// Registered write; the array commits it on the next edge
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			file_we    <= 1'b0;
			file_addr  <= '0;
			file_wdata <= 8'h00;
		end else begin
			file_addr <= instr[LBC_FADDR_W-1:0];
			if (op == LBC_ANDF && dest_file) begin
				file_we    <= 1'b1;
				file_wdata <= and_file;
			end else if (op == LBC_BCLR) begin
				file_we    <= 1'b1;
				file_wdata <= file_rdata & clr_mask;
			end else begin
				file_we    <= 1'b0;
			end
		end
	end

	// ********************************************************
	// Checks
	// ********************************************************
	sequence s_andf_acc;
		op == LBC_ANDF && !dest_file;
	endsequence

	a_andf_acc_dest: assert property (@(posedge sys_clk) disable iff (!nrst)
		s_andf_acc |=> accum == $past(and_file) && !file_we)
		else $error("register AND to accumulator wrong");

	a_andf_file_dest: assert property (@(posedge sys_clk) disable iff (!nrst)
		op == LBC_ANDF && dest_file |=> file_we && file_wdata == $past(and_file)
			&& $stable(accum))
		else $error("register AND to file wrong");

	a_andl_value: assert property (@(posedge sys_clk) disable iff (!nrst)
		op == LBC_ANDL |=> accum == ($past(accum) & $past(instr[7:0])))
		else $error("literal AND value wrong");

	a_andl_no_file: assert property (@(posedge sys_clk) disable iff (!nrst)
		op == LBC_ANDL |=> !file_we)
		else $error("literal AND wrote file");

	a_bclr_bit: assert property (@(posedge sys_clk) disable iff (!nrst)
		op == LBC_BCLR |=> file_we && !file_wdata[$past(instr[7:5])]
			&& $stable(zero_flag) && $stable(accum))
		else $error("bit clear wrong");

	a_bclr_others: assert property (@(posedge sys_clk) disable iff (!nrst)
		op == LBC_BCLR |=> (file_wdata | ~$past(clr_mask)) == ($past(file_rdata)
			| ~$past(clr_mask)))
		else $error("bit clear touched other bits");

	a_zero_flag_and: assert property (@(posedge sys_clk) disable iff (!nrst)
		op == LBC_ANDF || op == LBC_ANDL |=> zero_flag == (accum == 8'h00 && !file_we
			|| file_we && file_wdata == 8'h00))
		else $error("zero flag wrong");

	a_idle_quiet: assert property (@(posedge sys_clk) disable iff (!nrst)
		op == LBC_NONE |=> !file_we && $stable(zero_flag)
			&& accum == $past(acc_wr ? acc_wdata : accum))
		else $error("idle cycle changed state");

	// ********************************************************
	// Step sequences and further checks
	// ********************************************************
	// Each step names one decoded op so the properties read as the rules do
	sequence s_andf_file;
		op == LBC_ANDF && dest_file;
	endsequence

	sequence s_andl;
		op == LBC_ANDL;
	endsequence

	sequence s_bclr;
		op == LBC_BCLR;
	endsequence

	sequence s_idle;
		op == LBC_NONE;
	endsequence

	sequence s_acc_load;
		op == LBC_NONE && acc_wr;
	endsequence

	// Zero flag follows the register-form result, whichever destination
	a_andf_zero_flag: assert property (@(posedge sys_clk) disable iff (!nrst)
		op == LBC_ANDF |=> zero_flag == (($past(accum) & $past(file_rdata)) == 8'h00))
		else $error("register AND zero flag wrong");

	a_andl_zero_flag: assert property (@(posedge sys_clk) disable iff (!nrst)
		s_andl |=> zero_flag == (($past(accum) & $past(instr[7:0])) == 8'h00))
		else $error("literal AND zero flag wrong");

	// The write lands at the address the instruction named one cycle earlier
	a_andf_file_addr: assert property (@(posedge sys_clk) disable iff (!nrst)
		s_andf_file |=> file_addr == $past(instr[LBC_FADDR_W-1:0])
			&& file_wdata == ($past(accum) & $past(file_rdata)))
		else $error("register AND wrote wrong address");

	a_bclr_file_addr: assert property (@(posedge sys_clk) disable iff (!nrst)
		s_bclr |=> file_addr == $past(instr[LBC_FADDR_W-1:0]))
		else $error("bit clear wrote wrong address");

	// A file write only ever follows one of the two writing ops
	a_we_source: assert property (@(posedge sys_clk) disable iff (!nrst)
		file_we |-> $past(op == LBC_BCLR || op == LBC_ANDF && dest_file))
		else $error("file write without a writing op");

	// A write pulse lasts one cycle when an idle cycle follows the op
	a_we_one_cycle: assert property (@(posedge sys_clk) disable iff (!nrst)
		s_bclr ##1 s_idle |=> !file_we)
		else $error("file write pulse stretched");

	// Back to back: a literal AND right after a file write must not write again
	a_andf_then_andl: assert property (@(posedge sys_clk) disable iff (!nrst)
		s_andf_file ##1 s_andl |=> !file_we && accum == ($past(accum) & $past(instr[7:0])))
		else $error("back to back ops interfered");

	// Loaded value arrives in one cycle and leaves the zero flag alone
	a_acc_load: assert property (@(posedge sys_clk) disable iff (!nrst)
		s_acc_load |=> accum == $past(acc_wdata) && $stable(zero_flag) && !file_we)
		else $error("accumulator load wrong");

	// A load that meets one of our file-destination ops loses to it
	a_load_yields: assert property (@(posedge sys_clk) disable iff (!nrst)
		acc_wr && (op == LBC_BCLR || op == LBC_ANDF && dest_file) |=> $stable(accum))
		else $error("load overrode a file-destination op");

	// Bit clear leaves every status bit where it was, two in a row too
	a_bclr_pair: assert property (@(posedge sys_clk) disable iff (!nrst)
		s_bclr ##1 s_bclr |=> file_we && $stable(zero_flag) && $stable(accum))
		else $error("second bit clear wrong");

	// Reset values show at the first edge after release
	a_reset_values: assert property (@(posedge sys_clk)
		$rose(nrst) |-> accum == LBC_ACC_RST && zero_flag == LBC_ZERO_RST && !file_we)
		else $error("reset values wrong");

endmodule

// File: verilog/lbc_pkg.sv
package lbc_pkg;

	// ********************************************************
	// Instruction encoding
	// ********************************************************
	localparam int          LBC_IW         = 12;
	localparam int          LBC_DW         = 8;
	localparam logic [5:0]  LBC_OP_AND_FILE = 6'h05;  // Bits 11:6 = 0001 01
	localparam logic [3:0]  LBC_OP_AND_LIT  = 4'hE;   // Bits 11:8 = 1110
	localparam logic [3:0]  LBC_OP_BIT_CLR  = 4'h4;   // Bits 11:8 = 0100
	localparam int          LBC_DEST_BIT   = 5;
	localparam int          LBC_BSEL_LO    = 5;
	localparam int          LBC_FADDR_W    = 5;
	localparam logic [7:0]  LBC_ACC_RST    = 8'h00;
	localparam logic        LBC_ZERO_RST   = 1'b0;

	// Operation codes carried between decode and writeback
	typedef enum logic [3:0] {
		LBC_NONE  = 4'h1,
		LBC_ANDF  = 4'h2,
		LBC_ANDL  = 4'h4,
		LBC_BCLR  = 4'h8
	} lbc_op_t;

endpackage

// File: verilog/lbc_decode.sv
`timescale 1ns/10ps
module lbc_decode
	import lbc_pkg::*;
(
	input  wire logic [LBC_IW-1:0] instr,
	input  wire logic              instr_valid,
	output lbc_op_t                op
);

	// ********************************************************
	// Opcode classification
	// ********************************************************
	// Unrecognised words map to LBC_NONE so no file write or flag update follows
	always_comb begin
		op = LBC_NONE;
		if (instr_valid) begin
			if (instr[11:6] == LBC_OP_AND_FILE)
				op = LBC_ANDF;
			else if (instr[11:8] == LBC_OP_AND_LIT)
				op = LBC_ANDL;
			else if (instr[11:8] == LBC_OP_BIT_CLR)
				op = LBC_BCLR;
		end
	end

endmodule

// File: tb/lbc_file_model.sv
`timescale 1ns/10ps
module lbc_file_model
	import lbc_pkg::*;
(
	input  wire logic [LBC_FADDR_W-1:0] raddr,
	input  wire logic [LBC_FADDR_W-1:0] waddr,
	input  wire logic [LBC_DW-1:0]      wdata,
	input  wire logic                   we,
	input  wire logic                   sys_clk,
	output logic      [LBC_DW-1:0]      rdata
);
	// ****
	// File array
	// ****
	logic [LBC_DW-1:0] mem [32];
	// Known start pattern so the bench can mirror it
	initial for (int i = 0; i < 32; i++) mem[i] = 8'(i * 37 + 5);
	// No forwarding: a write lands one edge after it is offered
	always @(posedge sys_clk) if (we) mem[waddr] <= wdata;
	assign rdata = mem[raddr];
endmodule

// File: tb/logic_and_bit_clear_ops_bench.sv
`timescale 1ns/10ps
module logic_and_bit_clear_ops_bench;
	import lbc_pkg::*;
	logic        sys_clk = 1'b0;
	logic        nrst = 1'b0;
	logic        instr_valid = 1'b0;
	logic        acc_wr = 1'b0;
	logic [7:0]  acc_wdata = 8'h00;
	logic [11:0] instr = 12'h000;
	logic [7:0]  file_rdata, file_wdata, accum;
	logic [4:0]  file_addr;
	logic        file_we, zero_flag;
	logic [31:0] seed = 32'hCAF8;
	int          failures = 0, n_checks = 0, acc = 0, zf = 0, we = 0, wa, wd, v, k;
	int          mem [32];
	// ****
	// Clock and parts
	// ****
	always #5 sys_clk = ~sys_clk;
	lbc_core dut_u (.sys_clk, .nrst, .instr, .instr_valid, .acc_wr, .acc_wdata,
		.file_rdata, .file_addr,
		.file_wdata, .file_we, .accum, .zero_flag);
	lbc_file_model file_u (.sys_clk, .raddr(instr[4:0]), .rdata(file_rdata),
		.waddr(file_addr), .wdata(file_wdata), .we(file_we));
	// Xorshift keeps the stream repeatable
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic chk(input logic [7:0] got, input int exp);
		n_checks++;
		if (got !== exp[7:0]) begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp[7:0]);
		end
	endtask
	task automatic print_verdict;
		if (failures == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Random ops; the model lags file writes by one edge, as the array does
	initial begin
		for (int i = 0; i < 32; i++) mem[i] = (i * 37 + 5) & 255;
		repeat (2) @(posedge sys_clk);
		#1 nrst = 1'b1;
		for (int i = 0; i < 400; i++) begin
			@(posedge sys_clk);
			#1;
			chk(accum, acc);
			chk(8'(zero_flag), zf);
			chk(8'(file_we), we);
			if (we) chk(8'(file_addr), wa);
			if (we) chk(file_wdata, wd);
			// One mid-run reset: the pending file write is lost with file_we
			if (i == 200) begin
				nrst = 1'b0;
				instr_valid = 1'b0;
				acc_wr = 1'b0;
				acc = 0;
				zf = 0;
				we = 0;
				@(posedge sys_clk);
				#1 nrst = 1'b1;
				continue;
			end
			seed = xs(seed);
			k = seed[13:12];
			case (k)
				0: instr = {6'h05, seed[5:0]};
				1: instr = {4'hE, seed[7:0]};
				2: instr = {4'h4, seed[7:0]};
				default: instr = {seed[8] ? 4'hF : 4'hE, seed[7:0]};
			endcase
			instr_valid = k < 3 || seed[8];
			acc_wr = seed[20];
			acc_wdata = seed[31:24];
			// Loads from the rest of the core apply only in cycles with none of our ops
			if (acc_wr && !(instr_valid && k < 3)) acc = acc_wdata;
			v = mem[instr[4:0]];
			if (we) mem[wa] = wd;
			we = 0;
			wa = instr[4:0];
			// Both AND forms; only the register form may target the file
			if (instr_valid && k < 2) begin
				wd = acc & (k ? instr[7:0] : v);
				zf = wd == 0;
				we = k == 0 && instr[5];
				if (!we) acc = wd;
			end
			if (instr_valid && k == 2) begin
				we = 1;
				wd = v & ~(1 << instr[7:5]);
			end
		end
		print_verdict();
	end
endmodule
